// ---- src/afsf_pkg.sv ----
// FIFO status and error-flag block: shared constants and types.
// Assumes a Wishbone slave with 32-bit data, one word per register index.
package afsf_pkg;

  // =========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] AFSF_IDX_STATUS  = 8'h3B;
  localparam logic [7:0] AFSF_IDX_INT_EN  = 8'h3C;
  localparam logic [7:0] AFSF_IDX_EVENTS  = 8'h3D;
  localparam logic [7:0] AFSF_IDX_GENERAL = 8'h3E;

  // =========================================================
  // fifo status field positions
  localparam int AFSF_B_EMPTY = 0;
  localparam int AFSF_B_WMARK = 1;
  localparam int AFSF_B_OVR   = 2;
  localparam int AFSF_B_HIGH  = 4;
  localparam int AFSF_B_WRERR = 5;
  localparam int AFSF_B_RDERR = 6;
  localparam int AFSF_B_CTRL  = 7;
  localparam int AFSF_B_GEN_ERR = 0;

  // =========================================================
  // reset values
  localparam logic [7:0] AFSF_STATUS_RST = 8'h01;
  localparam logic [7:0] AFSF_INT_EN_RST = 8'h02;

  // =========================================================
  // fifo modes
  localparam logic [1:0] AFSF_MODE_OFF    = 2'h0;
  localparam logic [1:0] AFSF_MODE_WMARK  = 2'h1;
  localparam logic [1:0] AFSF_MODE_STREAM = 2'h2;

  // =========================================================
  // block state
  typedef struct packed {
    logic [8:0]  count;
    logic        wm_full;
    logic        rd_busy;
    logic [7:0]  flags;
    logic [7:0]  int_en;
    logic [7:0]  events;
    logic        gen_err;
    logic        irq;
    logic        ack;
    logic [31:0] rdata;
    logic        wr_grant;
    logic        rd_grant;
  } afsf_state_t;

endpackage

// ---- src/afsf_top.sv ----
// FIFO status flags: fill tracking, write/read arbitration, error flags,
// interrupt gating and the Wishbone register slave.
// Assumes the fifo storage, conversion core and serial port share clk_i.
`timescale 1ns/10ps
module afsf_top import afsf_pkg::*; #(
  parameter int DEPTH  = 256,
  parameter int DATA_W = 24,
  parameter int CHAN_W = 4
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [9:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic [31:0]            dat_o,
  output logic                   ack_o,
  // fifo configuration from the control registers
  input  wire logic [1:0]        fifo_mode_i,
  input  wire logic [7:0]        watermark_i,
  input  wire logic [DATA_W-1:0] high_limit_value_i,
  input  wire logic [2**CHAN_W-1:0] channel_limit_check_enable_i,
  // error register contents
  input  wire logic [7:0]        err_reg_i,
  // conversion core write request
  input  wire logic              conv_wr_i,
  input  wire logic [DATA_W-1:0] conv_data_i,
  input  wire logic [CHAN_W-1:0] conv_chan_i,
  // serial port read request
  input  wire logic              rd_req_i,
  // grants and status
  output logic                   wr_grant_o,
  output logic                   rd_grant_o,
  output logic                   emptied_o,
  output logic [7:0]             fifo_flag_status_o,
  output logic                   ctrl_err_o,
  output logic                   irq_o
);

  // =========================================================
  // state
  afsf_state_t st_reg;
  afsf_state_t st_next;
  logic        emptied_reg;
  logic        emptied_next;

  // =========================================================
  // combinational helpers
  logic        mode_on;
  logic        mode_wm;
  logic        mode_st;
  logic [8:0]  wm_limit;
  logic        wr_try;
  logic        wr_ok;
  logic        rd_ok;
  logic        rd_fail;
  logic        wr_coll;
  logic        wm_block;
  logic        overwrite;
  logic        empty_now;
  logic        over_lim;
  logic        bus_req;
  logic [7:0]  reg_idx;
  logic [8:0]  cnt_dec;
  logic [8:0]  cnt_inc;

  assign reg_idx = adr_i[9:2];
  assign bus_req = cyc_i & stb_i & ~st_reg.ack;
  assign cnt_inc = st_reg.count + 9'h001;
  assign cnt_dec = st_reg.count - 9'h001;

  // =========================================================
  // next-state logic
  always_comb begin
    st_next = st_reg;

    mode_wm = (fifo_mode_i == AFSF_MODE_WMARK);
    mode_st = (fifo_mode_i == AFSF_MODE_STREAM);
    mode_on = mode_wm | mode_st;

    // zero watermark stands for the whole depth
    wm_limit = (watermark_i == 8'h00) ? 9'(DEPTH)
                                      : {1'b0, watermark_i};

    // a read granted last cycle is still in progress and blocks writes
    wr_coll = conv_wr_i & st_reg.rd_busy;
    wr_try  = conv_wr_i & ~st_reg.rd_busy;

    wm_block  = mode_wm & st_reg.wm_full & wr_try;
    overwrite = mode_st & wr_try & (st_reg.count == 9'(DEPTH));
    wr_ok     = wr_try & ~wm_block
              & (overwrite | (st_reg.count < 9'(DEPTH)));

    // a taken write wins a tie; a refused write leaves the read free,
    // so a full watermark fifo can still be drained under conversions
    rd_fail = rd_req_i & wr_ok;
    rd_ok   = rd_req_i & ~wr_ok & (st_reg.count != 9'h000);

    // fill count; an overwrite keeps the count at depth
    if (wr_ok && !overwrite) begin
      st_next.count = cnt_inc;
    end else if (rd_ok) begin
      st_next.count = cnt_dec;
    end

    emptied_next = rd_ok & (st_reg.count == 9'h001);
    empty_now    = (st_next.count == 9'h000);
    over_lim     = (st_next.count >= wm_limit);

    // watermark full holds until the fifo is drained completely or watermark mode is left
    if (!mode_wm || emptied_next) begin
      st_next.wm_full = 1'b0;
    end else if (wr_ok && over_lim) begin
      st_next.wm_full = 1'b1;
    end

    st_next.rd_busy  = rd_ok;
    st_next.wr_grant = wr_ok;
    st_next.rd_grant = rd_ok;

    // write failure flag
    if (!mode_on) begin
      st_next.flags[AFSF_B_WRERR] = 1'b0;
    end else if (wr_coll || wm_block) begin
      st_next.flags[AFSF_B_WRERR] = 1'b1;
    end else if (emptied_next) begin
      st_next.flags[AFSF_B_WRERR] = 1'b0;
    end

    // overrun flag
    if (!mode_on) begin
      st_next.flags[AFSF_B_OVR] = 1'b0;
    end else if (wm_block || overwrite) begin
      st_next.flags[AFSF_B_OVR] = 1'b1;
    end else if (emptied_next) begin
      st_next.flags[AFSF_B_OVR] = 1'b0;
    end

    // read failure flag
    if (!mode_on) begin
      st_next.flags[AFSF_B_RDERR] = 1'b0;
    end else if (rd_fail) begin
      st_next.flags[AFSF_B_RDERR] = 1'b1;
    end else if (rd_ok) begin
      st_next.flags[AFSF_B_RDERR] = 1'b0;
    end

    // high limit flag on stored samples of checked channels
    if (!mode_on) begin
      st_next.flags[AFSF_B_HIGH] = 1'b0;
    end else if (wr_ok && channel_limit_check_enable_i[conv_chan_i]
                 && (conv_data_i >= high_limit_value_i)) begin
      st_next.flags[AFSF_B_HIGH] = 1'b1;
    end else if (emptied_next) begin
      st_next.flags[AFSF_B_HIGH] = 1'b0;
    end

    st_next.flags[AFSF_B_EMPTY] = empty_now;
    st_next.flags[AFSF_B_WMARK] = mode_wm & over_lim;
    st_next.flags[3]            = 1'b0;
    st_next.flags[AFSF_B_CTRL]  = |err_reg_i;
    st_next.gen_err             = st_next.flags[AFSF_B_CTRL];

    // register slave: one-cycle answer, ack dropped the cycle after
    st_next.ack   = bus_req;
    st_next.rdata = 32'h0000_0000;
    if (bus_req && we_i && sel_i[0] && reg_idx == AFSF_IDX_INT_EN) begin
      st_next.int_en = dat_i[7:0];
    end
    if (bus_req && !we_i) begin
      case (reg_idx)
        AFSF_IDX_STATUS:  st_next.rdata = {24'h000000, st_reg.flags};
        AFSF_IDX_INT_EN:  st_next.rdata = {24'h000000, st_reg.int_en};
        AFSF_IDX_EVENTS:  st_next.rdata = {24'h000000, st_reg.events};
        AFSF_IDX_GENERAL: st_next.rdata = {31'h00000000, st_reg.gen_err};
        default:          st_next.rdata = 32'h0000_0000;
      endcase
    end

    // sticky rising-edge log; a new edge beats the read clear
    if (bus_req && !we_i && reg_idx == AFSF_IDX_EVENTS) begin
      st_next.events = 8'h00;
    end
    st_next.events = st_next.events | (st_next.flags & ~st_reg.flags);

    // pin follows the enabled flags in the same cycle as the flags
    st_next.irq = |(st_next.flags & st_next.int_en);
  end

  // =========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg         <= '0;
      st_reg.flags   <= AFSF_STATUS_RST;
      st_reg.int_en  <= AFSF_INT_EN_RST;
      st_reg.irq     <= 1'b0;
      emptied_reg    <= 1'b0;
    end else begin
      st_reg      <= st_next;
      emptied_reg <= emptied_next;
    end
  end

  // =========================================================
  // outputs, all straight from flip-flops
  assign dat_o              = st_reg.rdata;
  assign ack_o              = st_reg.ack;
  assign wr_grant_o         = st_reg.wr_grant;
  assign rd_grant_o         = st_reg.rd_grant;
  assign emptied_o          = emptied_reg;
  assign fifo_flag_status_o = st_reg.flags;
  assign ctrl_err_o         = st_reg.gen_err;
  assign irq_o              = st_reg.irq;

endmodule // afsf_top

// ---- tb/afsf_assertions.sv ----
// checker: flag, grant and interrupt relations of afsf_top
// assumes it is bound onto afsf_top and sees only its ports
`timescale 1ns/10ps
module afsf_assertions import afsf_pkg::*; (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // requests and configuration
  input wire logic [1:0] fifo_mode_i,
  input wire logic [7:0] err_reg_i,
  input wire logic       conv_wr_i,
  input wire logic       rd_req_i,
  // answers
  input wire logic       wr_grant_o,
  input wire logic       rd_grant_o,
  input wire logic       emptied_o,
  input wire logic [7:0] fifo_flag_status_o,
  input wire logic       ctrl_err_o,
  input wire logic       irq_o
);
  // =========================================================
  // relations
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       act;
  logic [7:0] st;
  assign act = fifo_mode_i inside {AFSF_MODE_WMARK, AFSF_MODE_STREAM};
  assign st = fifo_flag_status_o;
  property p_off; (!act) [*2] |-> st[6:5] == 2'h0 && !st[2]; endproperty
  a_off: assert property (p_off)
    else $error("error flag outside active mode");
  property p_sum; (|err_reg_i) [*2] |-> st[7]; endproperty
  a_sum: assert property (p_sum)
    else $error("summary bit missing");
  property p_gen; st[7] |-> ctrl_err_o; endproperty
  a_gen: assert property (p_gen)
    else $error("general error bit missing");
  property p_one; !(wr_grant_o && rd_grant_o); endproperty
  a_one: assert property (p_one)
    else $error("both requests granted");
  property p_rdf; act && conv_wr_i && rd_req_i ##1 wr_grant_o
    |-> st[6]; endproperty
  a_rdf: assert property (p_rdf)
    else $error("refused read not flagged");
  property p_rdc; rd_grant_o |-> !st[6]; endproperty
  a_rdc: assert property (p_rdc)
    else $error("read flag kept after grant");
  property p_wrf; act && rd_grant_o && conv_wr_i && !rd_req_i
    |=> !wr_grant_o && st[5]; endproperty
  a_wrf: assert property (p_wrf)
    else $error("write during read not flagged");
  property p_wm; fifo_mode_i == AFSF_MODE_WMARK && st[1] && conv_wr_i
    && !rd_req_i |=> !wr_grant_o && st[5] && st[2]; endproperty
  a_wm: assert property (p_wm)
    else $error("write past watermark");
  property p_emp; emptied_o |-> st[0] && st[6:5] == 2'h0 && !st[2];
  endproperty
  a_emp: assert property (p_emp)
    else $error("flags kept after emptying");
  property p_irq; $rose(irq_o) |-> |st; endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without flag");
endmodule // afsf_assertions

bind afsf_top afsf_assertions u_afsf_chk (.*);

// ---- tb/afsf_host_model.sv ----
// host model: issues fifo reads and counts the granted ones
// assumes the bench commands each one-cycle read request
`timescale 1ns/10ps
module afsf_host_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // command and fifo answers
  input  wire logic       rd_i,
  input  wire logic       rd_grant_i,
  output logic            rd_req_o,
  output logic [8:0]      reads_o
);
  // =========================================================
  // host passes each commanded read request straight through, refused reads not retried
  assign rd_req_o = rd_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) reads_o <= 9'h000;
    else reads_o <= reads_o + {8'h00, rd_grant_i};
  end
endmodule // afsf_host_model

// ---- tb/test_adc_fifo_status_flags.sv ----
// bench: afsf_top against an integer model of fill and flags
// assumes default parameters and a 40 MHz clock
`timescale 1ns/10ps
module test_adc_fifo_status_flags import afsf_pkg::*; ;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic conv_wr_i = 0, rd_i = 0, rd_req_i, ack_o, wr_grant_o, rd_grant_o;
  logic emptied_o, ctrl_err_o, irq_o;
  logic [9:0]  adr_i = 10'h000;
  logic [31:0] dat_i = 32'h0, dat_o, rv;
  logic [1:0]  fifo_mode_i = 2'h0;
  logic [7:0]  watermark_i = 8'h00, err_reg_i = 8'h00, fifo_flag_status_o;
  logic [7:0]  ie = 8'h02;
  logic [23:0] conv_data_i = 24'h000000;
  logic [3:0]  conv_chan_i = 4'h0;
  logic [8:0]  reads;
  logic [2:0]  eg = 3'h0;
  int errors = 0, n_tests = 0, cnt = 0, wm, m = 0, nrd = 0;
  bit rb, wf, rf, ov, wmf, ev, act, ew, er;
  // =========================================================
  // design and host
  afsf_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i(4'h1), .dat_i, .dat_o, .ack_o, .fifo_mode_i, .watermark_i,
    .high_limit_value_i(24'hFFFFFF), .err_reg_i, .conv_wr_i,
    .channel_limit_check_enable_i(16'hFFFF), .conv_data_i,
    .conv_chan_i, .rd_req_i, .wr_grant_o, .rd_grant_o, .emptied_o,
    .fifo_flag_status_o, .ctrl_err_o, .irq_o);
  afsf_host_model host (.clk_i, .rst_i, .rd_i, .rd_grant_i(rd_grant_o),
    .rd_req_o(rd_req_i), .reads_o(reads));
  initial forever #12.5 clk_i = ~clk_i;
  // =========================================================
  // tasks
  function automatic logic [7:0] est();
    return {ev, rf, wf, 2'h0, ov, 1'b0, cnt == 0};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wb(input bit w, input logic [7:0] i, logic [31:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= {i, 2'h0};
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rv = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  // checks the previous request, then models this one
  task automatic op(input bit w, r);
    conv_wr_i <= w;
    rd_i <= r;
    conv_data_i <= 24'($urandom) & 24'h7FFFFF;
    conv_chan_i <= 4'($urandom);
    @(negedge clk_i);
    chk("grants", eg, {wr_grant_o, rd_grant_o, emptied_o});
    chk("status", est(), fifo_flag_status_o & 8'hFD);
    chk("irq", |(est() & ie), irq_o);
    chk("ctrl", ev, ctrl_err_o);
    act = m == 1 || m == 2;
    ew = w && !rb && (m == 2 || !(wmf || cnt == 256));
    er = r && !(w && ew) && cnt > 0;
    if (w && !ew && act) wf = 1;
    if (w && !rb && !ew && m == 1) ov = 1;
    if (r && ew && act) rf = 1;
    if (er) rf = 0;
    cnt = cnt + (ew && cnt < 256) - er;
    if (ew && m == 1 && cnt == wm) wmf = 1;
    if (er && cnt == 0) {wf, rf, ov, wmf} = 4'h0;
    eg = {ew, er, er && cnt == 0};
    rb = er;
    nrd += er;
    @(posedge clk_i);
  endtask
  task automatic cfg(input int md, input logic [7:0] e);
    fifo_mode_i <= 2'(md);
    err_reg_i <= e;
    op(0, 0);
    m = md;
    ev = |e;
    if (m != 1) wmf = 0;
    if (m == 0) {wf, rf, ov} = 3'h0;
  endtask
  // =========================================================
  // sequence
  initial begin
    #(25 * 4000);
    errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hE44CA108));
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, AFSF_IDX_STATUS, 0);
    chk("status_reg", 32'h01, rv);
    wb(0, 8'h10, 0);
    chk("unmapped", 32'h0, rv);
    ie = 8'h60 | (8'($urandom) & 8'h94);
    wb(1, AFSF_IDX_INT_EN, {24'h0, ie});
    wm = $urandom_range(3, 6);
    watermark_i <= 8'(wm);
    cfg(1, 0);
    repeat (wm + 1) op(1, 0);
    op(0, 0);
    wb(0, AFSF_IDX_STATUS, 0);
    chk("sticky", est(), rv & 32'hFD);
    while (cnt > 0) op(0, 1);
    op(1, 0);
    op(1, 1);
    op(0, 1);
    op(1, 0);
    while (cnt > 0) op(0, 1);
    cfg(2, 8'($urandom_range(1, 255)));
    op(1, 0);
    op(1, 0);
    op(0, 1);
    op(1, 0);
    while (cnt > 0) op(0, 1);
    cfg(0, 0);
    op(1, 1);
    op(0, 1);
    op(1, 0);
    op(0, 0);
    chk("reads", nrd, reads);
    stop_test();
  end
endmodule // test_adc_fifo_status_flags
